// [fws_bus_if.sv]
`timescale 1ns/1ns
interface fws_bus_if;
  import fws_pkg::*;
  logic              req;
  logic              wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic              done;
  modport master (output req, wr, addr, wdata, input rdata, done);
  modport slave  (input req, wr, addr, wdata, output rdata, done);
endinterface

// [fws_cycle.sv]
`timescale 1ns/1ns
module fws_cycle
  import fws_pkg::*;
(
  // Clock and reset.
  input  wire logic              sys_clk_i,
  input  wire logic              srst_i,
  // Cycle requests.
  fws_bus_if.slave               bus,
  // Flash pins.
  output logic                   flash_ce_n_o,
  output logic                   flash_oe_n_o,
  output logic                   flash_we_n_o,
  output logic [ADDR_W-1:0]      flash_addr_o,
  output logic [DATA_W-1:0]      flash_dq_o,
  output logic                   flash_dq_oe_o,
  input  wire logic [DATA_W-1:0] flash_dq_i
);
  import fws_pkg::*;

  typedef enum logic [2:0] {
    CY_IDLE   = 3'b001,
    CY_STROBE = 3'b010,
    CY_GAP    = 3'b100
  } fws_cy_t;

  fws_cy_t     st_q;
  logic [7:0]  cnt_q;
  logic        wr_q;
  logic [DATA_W-1:0] s1_q;
  logic [DATA_W-1:0] s2_q;

  // Data pins pass two flops before being read.
  always_ff @(posedge sys_clk_i) begin
    s1_q <= flash_dq_i;
    s2_q <= s1_q;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_q          <= CY_IDLE;
      cnt_q         <= 8'h00;
      wr_q          <= 1'b0;
      flash_ce_n_o  <= 1'b1;
      flash_oe_n_o  <= 1'b1;
      flash_we_n_o  <= 1'b1;
      flash_addr_o  <= '0;
      flash_dq_o    <= '0;
      flash_dq_oe_o <= 1'b0;
      bus.rdata     <= '0;
    end else begin
      case (st_q)
        CY_IDLE: begin
          if (bus.req) begin
            st_q          <= CY_STROBE;
            cnt_q         <= 8'(STROBE_CYC + 2);
            wr_q          <= bus.wr;
            flash_addr_o  <= bus.addr;
            flash_dq_o    <= bus.wdata;
            flash_dq_oe_o <= bus.wr;
            flash_ce_n_o  <= 1'b0;
            flash_oe_n_o  <= bus.wr;
            flash_we_n_o  <= ~bus.wr;
          end
        end
        CY_STROBE: begin
          if (cnt_q == 8'h01) begin
            // Every read ends with a rising strobe, so toggle bits advance.
            if (!wr_q) begin
              bus.rdata <= s2_q;
            end
            flash_ce_n_o <= 1'b1;
            flash_oe_n_o <= 1'b1;
            flash_we_n_o <= 1'b1;
            st_q         <= CY_GAP;
            cnt_q        <= 8'(GAP_CYC);
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        CY_GAP: begin
          flash_dq_oe_o <= 1'b0;
          if (cnt_q == 8'h01) begin
            st_q <= CY_IDLE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: st_q <= CY_IDLE;
      endcase
    end
  end

  assign bus.done = (st_q == CY_GAP) && (cnt_q == 8'h01);
endmodule

// [fws_flash_model.sv]
`timescale 1ns/1ns
module fws_flash_model
  import fws_pkg::*;
(
  // Host strobes and buses.
  input  wire logic              ce_n_i,
  input  wire logic              oe_n_i,
  input  wire logic              we_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] dq_i,
  // Device outputs.
  output logic      [DATA_W-1:0] dq_o,
  output logic                   ready_busy_output_o
);
  localparam int WIN_RD = 2;
  logic [DATA_W-1:0] arr, pend, last, st;
  logic              tog, stg, fail, ers, susp, prot, busy, pol;
  int                left, win;
  initial begin
    arr = '0;
    pend = '0;
    last = '0;
    {tog, stg, fail, ers, susp, prot} = 6'h00;
    left = 0;
    win = 0;
  end
  // Address bits 3:0 give the busy reads, bit 4 makes a program hang,
  // bit 5 starts a sector erase, bit 6 marks the sector protected and
  // bit 7 suspends or resumes a running erase.
  assign busy = fail || win > 0 || (left > 0 && !susp);
  assign ready_busy_output_o = !busy;
  assign pol = ers ? susp : ~pend[POL_BIT];
  assign st = {8'h00, pol, tog, fail, 1'b0, (win == 0), stg, 2'b00};
  assign dq_o = (!oe_n_i && !ce_n_i) ? ((busy || susp) ? st : arr)
                                     : ~last;
  always @(posedge we_n_i) begin
    if (ers && win == 0) begin
      // Once the window shuts only a suspend or resume is taken.
      if (addr_i[7])
        susp = ~susp;
    end else if (dq_i == RESET_CMD) begin
      fail = 1'b0;
      left = 0;
    end else if (addr_i[5]) begin
      ers = 1'b1;
      pend = '1;
      prot = addr_i[6];
      left = addr_i[3:0];
      win = WIN_RD;
    end else begin
      pend = dq_i;
      prot = addr_i[6];
      if (!addr_i[6])
        arr = dq_i;
      left = addr_i[3:0];
      fail = addr_i[4];
    end
  end
  always @(posedge oe_n_i) begin
    last = (busy || susp) ? st : arr;
    if (busy)
      tog = ~tog;
    if (ers)
      stg = ~stg;
    if (win > 0) begin
      win--;
    end else if (left > 0 && !susp && !fail) begin
      left--;
      if (left == 0 && ers) begin
        ers = 1'b0;
        if (!prot)
          arr = pend;
      end
    end
  end
endmodule

// [fws_pkg.sv]
package fws_pkg;
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned ADDR_W   = 22;
  // Status bit positions on the data bus.
  localparam int unsigned POL_BIT  = 7;
  localparam int unsigned TOG_BIT  = 6;
  localparam int unsigned TMO_BIT  = 5;
  localparam int unsigned WIN_BIT  = 3;
  localparam int unsigned STG_BIT  = 2;
  // Bus cycle timing in ns and derived cycles at 100 MHz.
  localparam int unsigned CLK_NS      = 10;
  localparam int unsigned STROBE_NS   = 70;
  localparam int unsigned STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned GAP_NS      = 30;
  localparam int unsigned GAP_CYC     = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SPACE_US    = 50;
  localparam int unsigned SPACE_CYC   = SPACE_US * 1000 / CLK_NS;
  localparam logic [15:0] RESET_CMD   = 16'h00f0;
  localparam logic [15:0] RESET_ADDR  = 16'h0000;
endpackage

// [fws_poll.sv]
`timescale 1ns/1ns
// Notes on behaviour
// - Host double-reads and compares toggle bit.
// - Toggling with timeout set: recheck, reset.
// - Interrupted polling restarts from double read.
// - Host issues reset after timeout failure.
// - Skip window check only under 50 us.
// - Host checks window before and after erase; the code reads it only on the final read after a command issued with cmd_win_i.
// - Host polls with a valid address.
module fws_poll
  import fws_pkg::*;
#(
  parameter int unsigned SPACE_CYCLES = SPACE_CYC
) (
  // Clock and reset.
  input  wire logic              sys_clk_i,
  input  wire logic              srst_i,
  // User commands.
  input  wire logic              cmd_valid_i,
  input  wire logic              cmd_wr_i,
  input  wire logic              cmd_poll_i,
  input  wire logic              cmd_win_i,
  input  wire logic [ADDR_W-1:0] cmd_addr_i,
  input  wire logic [DATA_W-1:0] cmd_data_i,
  output logic                   cmd_ready_o,
  // User results.
  output logic                   rsp_valid_o,
  output logic [DATA_W-1:0]      rsp_data_o,
  output logic                   rsp_fail_o,
  output logic                   rsp_win_o,
  output logic                   busy_o,
  output logic                   space_ok_o,
  // Flash pins.
  output logic                   flash_ce_n_o,
  output logic                   flash_oe_n_o,
  output logic                   flash_we_n_o,
  output logic [ADDR_W-1:0]      flash_addr_o,
  output logic [DATA_W-1:0]      flash_dq_o,
  output logic                   flash_dq_oe_o,
  input  wire logic [DATA_W-1:0] flash_dq_i,
  input  wire logic              flash_ready_busy_output_i
);
  import fws_pkg::*;

  typedef enum logic [6:0] {
    PS_IDLE  = 7'b0000001,
    PS_RD1   = 7'b0000010,
    PS_RD2   = 7'b0000100,
    PS_RD3   = 7'b0001000,
    PS_RST   = 7'b0010000,
    PS_FINAL = 7'b0100000,
    PS_ONE   = 7'b1000000
  } fws_ps_t;

  fws_bus_if bus ();

  fws_ps_t           st_q;
  logic              issued_q;
  logic              wr_q;
  logic              fail_q;
  logic              poll_q;
  logic              win_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] data_q;
  logic [DATA_W-1:0] first_q;
  logic [DATA_W-1:0] rsp_data_q;
  logic              rsp_valid_q;
  logic              rsp_fail_q;
  logic              rsp_win_q;
  logic              ryb_s1_q;
  logic              ryb_s2_q;
  logic [31:0]       space_q;
  logic              toggling;

  fws_cycle u_cycle (
    .sys_clk_i     (sys_clk_i),
    .srst_i        (srst_i),
    .bus           (bus.slave),
    .flash_ce_n_o  (flash_ce_n_o),
    .flash_oe_n_o  (flash_oe_n_o),
    .flash_we_n_o  (flash_we_n_o),
    .flash_addr_o  (flash_addr_o),
    .flash_dq_o    (flash_dq_o),
    .flash_dq_oe_o (flash_dq_oe_o),
    .flash_dq_i    (flash_dq_i)
  );

  // Open-drain ready line, pulled up outside.
  always_ff @(posedge sys_clk_i) begin
    ryb_s1_q <= flash_ready_busy_output_i;
    ryb_s2_q <= ryb_s1_q;
  end

  assign busy_o = ~ryb_s2_q;

  // Time since the last write, for back-to-back sector erase spacing.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      space_q <= 32'hffffffff;
    end else if (st_q == PS_ONE && bus.done && wr_q) begin
      space_q <= 32'h00000000;
    end else if (space_q != 32'hffffffff) begin
      space_q <= space_q + 32'h00000001;
    end
  end

  assign space_ok_o = space_q < SPACE_CYCLES;

  assign toggling = first_q[TOG_BIT] != bus.rdata[TOG_BIT];

  assign cmd_ready_o = (st_q == PS_IDLE);
  assign bus.req     = (st_q != PS_IDLE) && !issued_q;
  assign bus.wr      = (st_q == PS_RST) || (st_q == PS_ONE && wr_q);
  assign bus.addr    = (st_q == PS_RST) ? ADDR_W'(RESET_ADDR) : addr_q;
  assign bus.wdata   = (st_q == PS_RST) ? RESET_CMD : data_q;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_q     <= PS_IDLE;
      issued_q <= 1'b0;
      wr_q     <= 1'b0;
      fail_q   <= 1'b0;
      poll_q   <= 1'b0;
      win_q    <= 1'b0;
      addr_q   <= '0;
      data_q   <= '0;
      first_q  <= '0;
    end else begin
      if (bus.req) begin
        issued_q <= 1'b1;
      end else if (bus.done) begin
        issued_q <= 1'b0;
      end
      case (st_q)
        PS_IDLE: begin
          if (cmd_valid_i) begin
            addr_q <= cmd_addr_i;
            data_q <= cmd_data_i;
            wr_q   <= cmd_wr_i;
            poll_q <= cmd_poll_i;
            win_q  <= cmd_win_i;
            fail_q <= 1'b0;
            // Every poll without the write flag starts at the double read.
            st_q   <= (cmd_poll_i && !cmd_wr_i) ? PS_RD1 : PS_ONE;
          end
        end
        PS_ONE: begin
          if (bus.done) begin
            st_q <= PS_FINAL;
          end
        end
        PS_RD1: begin
          if (bus.done) begin
            first_q <= bus.rdata;
            st_q    <= PS_RD2;
          end
        end
        PS_RD2: begin
          if (bus.done) begin
            if (!toggling) begin
              st_q <= PS_FINAL;
            end else if (bus.rdata[TMO_BIT]) begin
              first_q <= bus.rdata;
              st_q    <= PS_RD3;
            end else begin
              first_q <= bus.rdata;
            end
          end
        end
        PS_RD3: begin
          if (bus.done) begin
            if (toggling) begin
              fail_q <= 1'b1;
              st_q   <= PS_RST;
            end else begin
              st_q <= PS_FINAL;
            end
          end
        end
        PS_RST: begin
          if (bus.done) begin
            st_q <= PS_FINAL;
          end
        end
        PS_FINAL: begin
          // Array data is valid only on the read after polling.
          if (bus.done) begin
            st_q <= PS_IDLE;
          end
        end
        default: st_q <= PS_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= '0;
      rsp_fail_q  <= 1'b0;
      rsp_win_q   <= 1'b0;
    end else begin
      rsp_valid_q <= (st_q == PS_FINAL) && bus.done;
      if (st_q == PS_FINAL && bus.done) begin
        rsp_data_q <= bus.rdata;
        rsp_fail_q <= fail_q;
        // A high window bit means the erase may not have been taken.
        rsp_win_q  <= win_q & bus.rdata[WIN_BIT];
      end
    end
  end

  assign rsp_valid_o = rsp_valid_q;
  assign rsp_data_o  = rsp_data_q;
  assign rsp_fail_o  = rsp_fail_q;
  assign rsp_win_o   = rsp_win_q;
endmodule

// [fws_poll_props.sv]
`timescale 1ns/1ns
module fws_poll_props
  import fws_pkg::*;
(
  // Clock and reset.
  input wire logic              sys_clk_i,
  input wire logic              srst_i,
  // User side.
  input wire logic              cmd_valid_i,
  input wire logic              cmd_poll_i,
  input wire logic              cmd_win_i,
  input wire logic [ADDR_W-1:0] cmd_addr_i,
  input wire logic              cmd_ready_o,
  input wire logic              rsp_valid_o,
  input wire logic [DATA_W-1:0] rsp_data_o,
  input wire logic              rsp_fail_o,
  input wire logic              rsp_win_o,
  // Flash side.
  input wire logic              flash_oe_n_o,
  input wire logic              flash_we_n_o,
  input wire logic [ADDR_W-1:0] flash_addr_o,
  input wire logic              flash_dq_oe_o,
  input wire logic [DATA_W-1:0] flash_dq_o,
  input wire logic [DATA_W-1:0] flash_dq_i
);
  logic              acc, poll_q, win_q, rst_q, tmo_q;
  logic [1:0]        rd_q;
  logic [ADDR_W-1:0] addr_q;
  assign acc = cmd_valid_i && cmd_ready_o;
  // Tracks the command in flight: reads, reset writes, timeout seen.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || acc) begin
      poll_q <= !srst_i && cmd_poll_i;
      win_q <= !srst_i && cmd_win_i;
      addr_q <= cmd_addr_i;
      rst_q <= 1'b0;
      tmo_q <= 1'b0;
      rd_q <= 2'h0;
    end else begin
      if ($rose(flash_oe_n_o) && rd_q != 2'h3)
        rd_q <= rd_q + 2'h1;
      if (!flash_we_n_o && flash_dq_o == RESET_CMD)
        rst_q <= 1'b1;
      if (!flash_oe_n_o && flash_dq_i[TMO_BIT])
        tmo_q <= 1'b1;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  a_poll_reads: assert property (rsp_valid_o && poll_q |-> rd_q == 2'h3)
    else $error("poll answered before three reads");
  a_poll_addr: assert property (poll_q && !flash_oe_n_o
    |-> flash_addr_o == addr_q) else $error("poll read at wrong address");
  a_fail_reset: assert property (rsp_valid_o && rsp_fail_o |-> rst_q)
    else $error("failure without reset command");
  a_fail_tmo: assert property (rsp_valid_o && rsp_fail_o |-> tmo_q)
    else $error("failure without timeout bit");
  a_win_report: assert property (rsp_valid_o
    |-> rsp_win_o == (win_q && rsp_data_o[WIN_BIT]))
    else $error("window flag wrong");
  a_ready_idle: assert property (cmd_ready_o
    |-> flash_oe_n_o && flash_we_n_o) else $error("ready mid cycle");
  a_reset_cmd: assert property (poll_q && !flash_we_n_o
    |-> flash_dq_o == RESET_CMD && flash_addr_o == ADDR_W'(RESET_ADDR))
    else $error("bad write during poll");
  a_dq_no_fight: assert property (!flash_oe_n_o |-> !flash_dq_oe_o)
    else $error("data driven during a read");
  a_dq_drive_wr: assert property (!flash_we_n_o |-> flash_dq_oe_o)
    else $error("data released during a write");
  c_poll: cover property (rsp_valid_o && poll_q);
  c_fail: cover property (rsp_valid_o && rsp_fail_o);
  c_win: cover property (rsp_valid_o && rsp_win_o);
endmodule

// [fws_poll_test.sv]
`timescale 1ns/1ns
module fws_poll_test;
  import fws_pkg::*;
  logic              clk, rst, vld, wr, poll, win;
  logic              rdy, rv, rf, rw, bsy, sok;
  logic              ce_n, oe_n, we_n, doe, ry;
  logic [ADDR_W-1:0] adr, fa;
  logic [DATA_W-1:0] wd, rd, fdo, fdi;
  int                n_fail, checked;
  fws_poll #(.SPACE_CYCLES(50)) u_fws_poll (
    .sys_clk_i(clk), .srst_i(rst), .cmd_valid_i(vld), .cmd_wr_i(wr),
    .cmd_poll_i(poll), .cmd_win_i(win), .cmd_addr_i(adr),
    .cmd_data_i(wd), .cmd_ready_o(rdy), .rsp_valid_o(rv),
    .rsp_data_o(rd), .rsp_fail_o(rf), .rsp_win_o(rw), .busy_o(bsy),
    .space_ok_o(sok), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n),
    .flash_we_n_o(we_n), .flash_addr_o(fa), .flash_dq_o(fdo),
    .flash_dq_oe_o(doe), .flash_dq_i(fdi), .flash_ready_busy_output_i(ry));
  fws_flash_model u_fws_flash_model (.ce_n_i(ce_n), .oe_n_i(oe_n),
    .we_n_i(we_n), .addr_i(fa), .dq_i(fdo), .dq_o(fdi), .ready_busy_output_o(ry));
  task chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task cmd(input logic w, p, n, input logic [ADDR_W-1:0] a,
           input logic [DATA_W-1:0] d);
    @(posedge clk);
    vld <= 1'b1;
    wr <= w;
    poll <= p;
    win <= n;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (!rdy) @(posedge clk);
    vld <= 1'b0;
    for (int i = 0; i < 3000 && rv !== 1'b1; i++) @(posedge clk);
    chk(rv === 1'b1, "no response");
  endtask
  task t_prog;
    cmd(1, 0, 0, 22'h000003, 16'h1234);
    chk(rf === 1'b0, "write failed");
    chk(sok === 1'b1, "spacing flag low");
    cmd(0, 1, 0, 22'h000003, 16'h0000);
    chk(rd === 16'h1234, "poll data");
    chk(rf === 1'b0, "poll failed");
    repeat (60) @(posedge clk);
    chk(sok === 1'b0, "spacing flag high");
  endtask
  task t_win;
    cmd(1, 0, 0, 22'h00000f, 16'h0055);
    chk(bsy === 1'b1, "not busy");
    cmd(0, 0, 1, 22'h00000f, 16'h0000);
    chk(rw === 1'b1, "window flag");
    chk(rd[POL_BIT] === 1'b1, "polarity");
    cmd(0, 1, 1, 22'h00000f, 16'h0000);
    chk(rd === 16'h0055, "data after poll");
    chk(rw === 1'b0, "window from data");
  endtask
  task t_fail;
    cmd(1, 0, 0, 22'h000010, 16'h0008);
    cmd(0, 1, 1, 22'h000010, 16'h0000);
    chk(rf === 1'b1, "no failure");
    chk(rd === 16'h0008, "data after reset");
    chk(rw === 1'b1, "window bit");
    chk(bsy === 1'b0, "still busy");
  endtask
  task t_erase;
    logic s, t;
    cmd(1, 0, 0, 22'h000024, 16'h0000);
    chk(rd[POL_BIT] === 1'b0, "polarity in erase");
    chk(rd[WIN_BIT] === 1'b0, "window closed early");
    s = rd[STG_BIT];
    cmd(1, 0, 1, 22'h000024, 16'h0000);
    chk(rw === 1'b0, "extra erase refused");
    chk(rd[STG_BIT] === ~s, "sector bit still");
    cmd(0, 0, 1, 22'h000024, 16'h0000);
    chk(rw === 1'b1, "window not closed");
    cmd(1, 0, 0, 22'h000010, 16'h1111);
    chk(rd[TMO_BIT] === 1'b0, "write taken in erase");
    cmd(1, 0, 0, 22'h000080, 16'h0000);
    chk(rd[POL_BIT] === 1'b1, "polarity in suspend");
    chk(bsy === 1'b0, "busy in suspend");
    t = rd[TOG_BIT];
    cmd(0, 0, 0, 22'h000080, 16'h0000);
    chk(rd[TOG_BIT] === t, "toggle in suspend");
    cmd(1, 0, 0, 22'h000080, 16'h0000);
    cmd(0, 1, 0, 22'h000024, 16'h0000);
    chk(rd === 16'hffff, "erased data");
    chk(rf === 1'b0, "erase failed");
    cmd(1, 0, 0, 22'h000001, 16'h00a5);
    cmd(1, 0, 0, 22'h000062, 16'h0000);
    cmd(0, 1, 0, 22'h000062, 16'h0000);
    chk(rd === 16'h00a5, "protected erase");
    cmd(1, 0, 0, 22'h000041, 16'h0011);
    cmd(0, 0, 0, 22'h000041, 16'h0000);
    chk(rd === 16'h00a5, "protected program");
  endtask
  task end_sim;
    $display("fails %0d checks %0d", n_fail, checked);
    if (n_fail == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #300000;
    n_fail++;
    end_sim;
  end
  initial begin
    {rst, vld, wr, poll, win} = 5'h10;
    adr = '0;
    wd = '0;
    n_fail = 0;
    checked = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_prog;
    t_win;
    t_fail;
    t_erase;
    end_sim;
  end
endmodule
bind fws_poll fws_poll_props u_fws_poll_props (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid_i),
  .cmd_poll_i(cmd_poll_i), .cmd_win_i(cmd_win_i),
  .cmd_addr_i(cmd_addr_i), .cmd_ready_o(cmd_ready_o),
  .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
  .rsp_fail_o(rsp_fail_o), .rsp_win_o(rsp_win_o),
  .flash_oe_n_o(flash_oe_n_o), .flash_we_n_o(flash_we_n_o),
  .flash_addr_o(flash_addr_o), .flash_dq_o(flash_dq_o),
  .flash_dq_oe_o(flash_dq_oe_o), .flash_dq_i(flash_dq_i));
